//--- hdl/sbgr_pkg.sv
// Function
// RL1: each sequence B conversion loads its 12-bit value into bits 15:4, replacing the old one.
// RL2: conversions of any other sequence leave the register untouched.
// RL3: the result is an unsigned fraction of the reference span, 0 at the bottom, 0xfff at the top.
// RL4: bit 31 goes to 1 at the end of each conversion, when the new value is loaded.
// RL5: any bus read of the register clears bit 31; a read in the same cycle as a load leaves it set.
// RL6: bit 30 is set when a value is loaded while bit 31 is still 1.
// RL7: the same read that clears bit 31 clears bit 30.
// RL8: bit 30 feeds the overrun request only with mode bit 0 and the overrun enable on.
// RL9: bit 31 raises the conversion-complete request with mode bit 0 and its enable on.
// RL10: bits 17:16 give 0 in range, 1 below low, 2 above high, never 3.
// RL11: crossing compares only against the low threshold, old sample against new, per channel.
// RL12: bits 19:18 give 0 for no change, 2 for downward, 3 for upward, never 1.
// RL13: bits 29:26 hold the channel number that produced the stored result.
// RL14: software writes no ones to bits 3:0 and 25:20 and ignores what they read.
// RL15: the register ignores writes, and both flags read 0 after reset.
package sbgr_pkg;

   // byte addresses on the peripheral bus
   localparam logic [31:0] ADDR_GLOBAL_RESULT = 32'h4001c014;
   localparam logic [31:0] ADDR_SEQ_B_CONTROL = 32'h4001c100;
   localparam logic [31:0] ADDR_LOW_THRESHOLD = 32'h4001c104;
   localparam logic [31:0] ADDR_HIGH_THRESHOLD = 32'h4001c108;
   localparam logic [31:0] ADDR_INT_STATUS = 32'h4001c10c;
   localparam logic [31:0] ADDR_INT_MASK = 32'h4001c110;

   // result word field positions
   localparam int RESULT_LSB = 4;
   localparam int RANGE_LSB = 16;
   localparam int CROSS_LSB = 18;
   localparam int CHAN_LSB = 26;
   localparam int OVERRUN_BIT = 30;
   localparam int FRESH_BIT = 31;

   // control word bits
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_DONE_EN_BIT = 1;
   localparam int CTRL_OVR_EN_BIT = 2;

   // interrupt status and mask bits
   localparam int INT_DONE_BIT = 0;
   localparam int INT_OVR_BIT = 1;

   // reset values
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [11:0] LOW_RESET = 12'h000;
   localparam logic [11:0] HIGH_RESET = 12'hfff;
   localparam logic [1:0] INT_RESET = 2'h0;

   // codes
   localparam logic [1:0] RANGE_IN = 2'h0;
   localparam logic [1:0] RANGE_BELOW = 2'h1;
   localparam logic [1:0] RANGE_ABOVE = 2'h2;
   localparam logic [1:0] CROSS_NONE = 2'h0;
   localparam logic [1:0] CROSS_DOWN = 2'h2;
   localparam logic [1:0] CROSS_UP = 2'h3;

   // one completed conversion from the sequencer
   typedef struct packed {
      logic done;
      logic seq_b;
      logic [3:0] channel;
      logic [11:0] result;
   } sbgr_conv_s;

   // threshold comparison outcome
   typedef struct packed {
      logic [1:0] range_code;
      logic [1:0] cross_code;
   } sbgr_cmp_s;

endpackage

//--- hdl/sbgr_ahb_slave.sv
`timescale 1ns/10ps
module sbgr_ahb_slave
   import sbgr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // ahb-lite slave side
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   // register side strobes
   output logic rd_stb,
   output logic [31:0] rd_addr,
   output logic wr_stb,
   output logic [31:0] wr_addr
);

   logic accept;
   logic wr_pend_reg;
   logic [31:0] wr_addr_reg;

   // address phase accepted on nonseq or seq; zero wait states, always okay
   assign accept = hsel && hready && htrans[1];
   assign rd_stb = accept && !hwrite;
   assign rd_addr = haddr;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_stb = wr_pend_reg;
   assign wr_addr = wr_addr_reg;

   // write address kept for the data phase, where hwdata stands
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 32'h00000000;
      end
      else
      begin
         wr_pend_reg <= accept && hwrite;
         if (accept)
            wr_addr_reg <= haddr;
      end
   end

endmodule

//--- hdl/sbgr_threshold_cmp.sv
`timescale 1ns/10ps
module sbgr_threshold_cmp
   import sbgr_pkg::*;
#(
   parameter int CHANNELS = 12
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // sample and thresholds
   input wire logic load,
   input wire logic [3:0] channel,
   input wire logic [11:0] result,
   input wire logic [11:0] low_threshold,
   input wire logic [11:0] high_threshold,
   // codes for the sample now offered
   output sbgr_cmp_s cmp
);

   logic [CHANNELS-1:0] below_reg;
   logic [CHANNELS-1:0] seen_reg;
   logic below_now;
   logic below_prev;
   logic seen_prev;
   logic chan_ok;

   assign chan_ok = 32'(channel) < CHANNELS;
   assign below_now = result < low_threshold;
   assign below_prev = chan_ok ? below_reg[channel] : 1'b0;
   assign seen_prev = chan_ok ? seen_reg[channel] : 1'b0;

   // range and crossing codes; a first sample on a channel has no crossing
   always_comb
   begin
      if (below_now)
         cmp.range_code = RANGE_BELOW; // [RL10]
      else if (result > high_threshold)
         cmp.range_code = RANGE_ABOVE; // [RL10]
      else
         cmp.range_code = RANGE_IN; // [RL10]
      if (!seen_prev || below_prev == below_now)
         cmp.cross_code = CROSS_NONE; // [RL11] [RL12]
      else if (below_now)
         cmp.cross_code = CROSS_DOWN; // [RL11] [RL12]
      else
         cmp.cross_code = CROSS_UP; // [RL11] [RL12]
   end

   // per-channel history against the low threshold only
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         below_reg <= '0;
         seen_reg <= '0;
      end
      else if (load && chan_ok)
      begin
         below_reg[channel] <= below_now; // [RL11]
         seen_reg[channel] <= 1'b1;
      end
   end

   AST_RANGE_NOT_3: assert property (@(posedge clock) disable iff (!rst_n) // [RL10]
      cmp.range_code != 2'h3) else $error("range code 3 produced");
   AST_CROSS_NOT_1: assert property (@(posedge clock) disable iff (!rst_n) // [RL12]
      cmp.cross_code != 2'h1) else $error("crossing code 1 produced");
   AST_CROSS_DOWN: assert property (@(posedge clock) disable iff (!rst_n) // [RL11]
      load && chan_ok && !below_now ##1 load && $stable(channel) && below_now
      |-> cmp.cross_code == CROSS_DOWN) else $error("downward crossing missed");

endmodule

//--- hdl/sbgr_global_result.sv
`timescale 1ns/10ps
module sbgr_global_result
   import sbgr_pkg::*;
#(
   parameter int CHANNELS = 12
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // completed conversions from the sequencer
   input wire sbgr_conv_s conv,
   // interrupt requests
   output logic done_req,
   output logic overrun_req,
   output logic irq
);

   logic rd_stb;
   logic [31:0] rd_addr;
   logic wr_stb;
   logic [31:0] wr_addr;
   logic load;
   logic rd_gdat;
   sbgr_cmp_s cmp;
   logic [11:0] result_reg;
   logic [3:0] chan_reg;
   logic [1:0] range_reg;
   logic [1:0] cross_reg;
   logic fresh_reg;
   logic overrun_reg;
   logic [2:0] ctrl_reg;
   logic [11:0] low_reg;
   logic [11:0] high_reg;
   logic [1:0] status_reg;
   logic [1:0] mask_reg;
   logic [1:0] events;
   logic [31:0] gdat_word;
   logic [31:0] rd_word;
   logic [31:0] hrdata_reg;
   logic mode_zero;

   // bus slave
   sbgr_ahb_slave sbgr_ahb_slave_i
   (
      .clock(clock),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .rd_stb(rd_stb),
      .rd_addr(rd_addr),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr)
   );

   // threshold range and crossing logic
   sbgr_threshold_cmp #(
      .CHANNELS(CHANNELS)
   ) sbgr_threshold_cmp_i
   (
      .clock(clock),
      .rst_n(rst_n),
      .load(load),
      .channel(conv.channel),
      .result(conv.result),
      .low_threshold(low_reg),
      .high_threshold(high_reg),
      .cmp(cmp)
   );

   // only sequence b conversions are captured
   assign load = conv.done && conv.seq_b; // [RL2]
   assign rd_gdat = rd_stb && rd_addr == ADDR_GLOBAL_RESULT;
   assign mode_zero = !ctrl_reg[CTRL_MODE_BIT];

   // captured conversion fields, overwritten on each load
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_reg <= 12'h000;
         chan_reg <= 4'h0;
         range_reg <= RANGE_IN;
         cross_reg <= CROSS_NONE;
      end
      else if (load)
      begin
         result_reg <= conv.result; // [RL1] [RL3]
         chan_reg <= conv.channel; // [RL13]
         range_reg <= cmp.range_code; // [RL10]
         cross_reg <= cmp.cross_code; // [RL12]
      end
   end

   // fresh flag: set on load, cleared by a read; a load wins over a read
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         fresh_reg <= 1'b0; // [RL15]
      else if (load)
         fresh_reg <= 1'b1; // [RL4]
      else if (rd_gdat)
         fresh_reg <= 1'b0; // [RL5]
   end

   // overrun flag: set on a load over an unread result, cleared by the same read
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         overrun_reg <= 1'b0; // [RL15]
      else if (load && fresh_reg)
         overrun_reg <= 1'b1; // [RL6]
      else if (rd_gdat)
         overrun_reg <= 1'b0; // [RL7]
   end

   // software-written control and thresholds
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg <= CTRL_RESET;
         low_reg <= LOW_RESET;
         high_reg <= HIGH_RESET;
         mask_reg <= INT_RESET;
      end
      else if (wr_stb)
      begin
         case (wr_addr)
            ADDR_SEQ_B_CONTROL: ctrl_reg <= hwdata[2:0];
            ADDR_LOW_THRESHOLD: low_reg <= hwdata[RESULT_LSB +: 12];
            ADDR_HIGH_THRESHOLD: high_reg <= hwdata[RESULT_LSB +: 12];
            ADDR_INT_MASK: mask_reg <= hwdata[1:0];
            default: ctrl_reg <= ctrl_reg; // result word is read-only [RL15]
         endcase
      end
   end

   // sticky events, only in per-conversion mode with the matching enable
   always_comb
   begin
      events = 2'h0;
      events[INT_DONE_BIT] = load && mode_zero && ctrl_reg[CTRL_DONE_EN_BIT];
      events[INT_OVR_BIT] = load && fresh_reg && mode_zero && ctrl_reg[CTRL_OVR_EN_BIT];
   end

   // status cleared by writing ones; a new event wins over the clear
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         status_reg <= INT_RESET;
      else if (wr_stb && wr_addr == ADDR_INT_STATUS)
         status_reg <= (status_reg & ~hwdata[1:0]) | events;
      else
         status_reg <= status_reg | events;
   end

   // request levels and the single interrupt line
   assign done_req = fresh_reg && mode_zero && ctrl_reg[CTRL_DONE_EN_BIT]; // [RL9]
   assign overrun_req = overrun_reg && mode_zero && ctrl_reg[CTRL_OVR_EN_BIT]; // [RL8]
   assign irq = |(status_reg & mask_reg);

   // result word; reserved bits read as zero
   always_comb
   begin
      gdat_word = 32'h00000000;
      gdat_word[RESULT_LSB +: 12] = result_reg;
      gdat_word[RANGE_LSB +: 2] = range_reg;
      gdat_word[CROSS_LSB +: 2] = cross_reg;
      gdat_word[CHAN_LSB +: 4] = chan_reg;
      gdat_word[OVERRUN_BIT] = overrun_reg;
      gdat_word[FRESH_BIT] = fresh_reg;
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      rd_word = 32'h00000000;
      case (rd_addr)
         ADDR_GLOBAL_RESULT: rd_word = gdat_word;
         ADDR_SEQ_B_CONTROL: rd_word[2:0] = ctrl_reg;
         ADDR_LOW_THRESHOLD: rd_word[RESULT_LSB +: 12] = low_reg;
         ADDR_HIGH_THRESHOLD: rd_word[RESULT_LSB +: 12] = high_reg;
         ADDR_INT_STATUS: rd_word[1:0] = status_reg;
         ADDR_INT_MASK: rd_word[1:0] = mask_reg;
         default: rd_word = 32'h00000000;
      endcase
   end

   // read data captured at the address phase, presented in the data phase
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         hrdata_reg <= 32'h00000000;
      else if (rd_stb)
         hrdata_reg <= rd_word;
   end

   assign hrdata = hrdata_reg;

   // sequences used by the checks below
   sequence s_load;
      load;
   endsequence

   sequence s_read_only;
      rd_gdat && !load;
   endsequence

   sequence s_load_unread;
      load && fresh_reg;
   endsequence

   AST_LOAD_RESULT: assert property (@(posedge clock) disable iff (!rst_n) // [RL1]
      s_load |=> result_reg == $past(conv.result) && gdat_word[15:4] == $past(conv.result))
      else $error("result not loaded");

   AST_OTHER_SEQ: assert property (@(posedge clock) disable iff (!rst_n) // [RL2]
      conv.done && !conv.seq_b |=> $stable(result_reg) && $stable(chan_reg))
      else $error("foreign sequence changed result");

   AST_FULL_SCALE: assert property (@(posedge clock) disable iff (!rst_n) // [RL3]
      load && conv.result == 12'hfff |=> gdat_word[15:4] == 12'hfff)
      else $error("full scale code lost");

   AST_FRESH_SET: assert property (@(posedge clock) disable iff (!rst_n) // [RL4]
      s_load |=> fresh_reg) else $error("fresh flag not set on load");

   AST_READ_CLEARS_FRESH: assert property (@(posedge clock) disable iff (!rst_n) // [RL5]
      s_read_only |=> !fresh_reg) else $error("read left fresh flag set");

   AST_OVERRUN_SET: assert property (@(posedge clock) disable iff (!rst_n) // [RL6]
      s_load_unread ##1 !rd_gdat |=> overrun_reg) else $error("overrun not held");

   AST_READ_CLEARS_BOTH: assert property (@(posedge clock) disable iff (!rst_n) // [RL7]
      s_read_only |=> !overrun_reg && !fresh_reg) else $error("read left overrun set");

   AST_OVERRUN_REQ: assert property (@(posedge clock) disable iff (!rst_n) // [RL8]
      overrun_req == (overrun_reg && !ctrl_reg[0] && ctrl_reg[2]))
      else $error("overrun request wrong");

   AST_DONE_REQ: assert property (@(posedge clock) disable iff (!rst_n) // [RL9]
      s_load ##1 (!ctrl_reg[0] && ctrl_reg[1]) |-> done_req)
      else $error("complete request missing");

   AST_CHANNEL: assert property (@(posedge clock) disable iff (!rst_n) // [RL13]
      s_load |=> gdat_word[29:26] == $past(conv.channel)) else $error("channel wrong");

   AST_NO_WRITE: assert property (@(posedge clock) disable iff (!rst_n) // [RL15]
      wr_stb && !load |=> $stable(result_reg) && !$rose(fresh_reg))
      else $error("write disturbed result");

   // field, range and request checks as software sees them
   AST_KEEP_WITHOUT_LOAD: assert property (@(posedge clock) disable iff (!rst_n) // [RL2]
      !load |=> $stable(result_reg) && $stable(chan_reg))
      else $error("result changed without a sequence b load");

   AST_READ_SHOWS_FRESH: assert property (@(posedge clock) disable iff (!rst_n) // [RL5]
      rd_gdat |=> hrdata[FRESH_BIT] == $past(fresh_reg))
      else $error("read data lost the fresh flag");

   AST_RANGE_BELOW: assert property (@(posedge clock) disable iff (!rst_n) // [RL10]
      s_load && conv.result < low_reg |=> gdat_word[17:16] == RANGE_BELOW)
      else $error("below range code missing");

   AST_RANGE_ABOVE: assert property (@(posedge clock) disable iff (!rst_n) // [RL10]
      s_load && conv.result >= low_reg && conv.result > high_reg |=> gdat_word[17:16] == RANGE_ABOVE)
      else $error("above range code missing");

   AST_RANGE_IN: assert property (@(posedge clock) disable iff (!rst_n) // [RL10]
      s_load && conv.result >= low_reg && conv.result <= high_reg |=> gdat_word[17:16] == RANGE_IN)
      else $error("in range code missing");

   AST_CROSS_CAPTURED: assert property (@(posedge clock) disable iff (!rst_n) // [RL12]
      s_load |=> gdat_word[19:18] != 2'h1)
      else $error("reserved crossing code stored");

   AST_SEQ_MODE_NO_OVR: assert property (@(posedge clock) disable iff (!rst_n) // [RL8]
      ctrl_reg[CTRL_MODE_BIT] |-> !overrun_req)
      else $error("overrun request in sequence mode");

   AST_SEQ_MODE_NO_DONE: assert property (@(posedge clock) disable iff (!rst_n) // [RL9]
      ctrl_reg[CTRL_MODE_BIT] |-> !done_req)
      else $error("complete request in sequence mode");

endmodule

//--- tb/sbgr_ahb_master.sv
`timescale 1ns/10ps
module sbgr_ahb_master
   import sbgr_pkg::*;
(
   // clock and bus answer
   input wire logic clock,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // bus request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // idle bus from time zero
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // one address phase, held until hready is sampled high
   task automatic addr_phase(input logic [31:0] a, input logic w);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clock);
      while (hready !== 1'b1)
         @(posedge clock);
   endtask

   // data phase ends at the next edge with hready high
   task automatic data_wait;
      @(posedge clock);
      while (hready !== 1'b1)
         @(posedge clock);
   endtask

   // single word read, data taken at the closing edge
   task automatic read(input logic [31:0] a, output logic [31:0] d);
      addr_phase(a, 1'b0);
      htrans <= 2'h0;
      data_wait();
      d = hrdata;
   endtask

   // single word write; reserved result bits kept low
   task automatic write(input logic [31:0] a, input logic [31:0] d);
      addr_phase(a, 1'b1);
      htrans <= 2'h0;
      hwdata <= (a == ADDR_GLOBAL_RESULT) ? (d & 32'hfc0ffff0) : d;
      data_wait();
   endtask
endmodule

//--- tb/tb_sbgr_global_result.sv
`timescale 1ns/10ps
module tb_sbgr_global_result
   import sbgr_pkg::*;
;
   logic clock;
   logic rst_n;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic hready;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hresp;
   sbgr_conv_s conv;
   logic done_req;
   logic overrun_req;
   logic irq;
   int n_mismatch;
   int comparisons;
   int cycles;
   logic [31:0] d;
   logic [31:0] last;
   // table entries: channel, range code, crossing code, result
   localparam logic [19:0] TBL [9] = '{20'h14123, 20'h243ff, 20'h23400, 20'h20c00,
      20'h28c01, 20'h28fff, 20'h26000, 20'h30800, 20'h23800};

   // design under test and bus master
   sbgr_global_result #(.CHANNELS(12)) sbgr_global_result_i (.clock(clock), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .conv(conv), .done_req(done_req), .overrun_req(overrun_req), .irq(irq));
   sbgr_ahb_master sbgr_ahb_master_i (.clock(clock), .hready(hready), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));

   // 50 MHz clock
   always #10 clock = ~clock;

   // result word as software should see it
   function automatic logic [31:0] word(logic f, logic o, logic [19:0] e);
      return {f, o, e[19:16], 6'h0, e[13:12], e[15:14], e[11:0], 4'h0};
   endfunction

   // compare and count
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // read a register and compare it
   task automatic rchk(string name, logic [31:0] a, logic [31:0] exp);
      sbgr_ahb_master_i.read(a, d);
      chk(name, exp, d);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   // check the three request outputs after the last edge settles
   task automatic reqs(logic [2:0] exp);
      #1;
      chk("done_req overrun_req irq", {29'h0, exp}, {29'h0, done_req, overrun_req, irq});
   endtask

   // one conversion pulse from the sequencer
   task automatic pulse(logic sb, logic [3:0] ch, logic [11:0] r);
      @(posedge clock);
      conv <= {1'b1, sb, ch, r};
      @(posedge clock);
      conv <= '0;
   endtask

   // verdict and end of run
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   // main sequence
   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      conv = '0;
      n_mismatch = 0;
      comparisons = 0;
      cycles = 0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      reqs(3'h0);
      rchk("result", ADDR_GLOBAL_RESULT, 32'h0);
      rchk("high", ADDR_HIGH_THRESHOLD, 32'h0000fff0);
      rchk("unmapped", 32'h4001c018, 32'h0);
      $display("reset test done");
      sbgr_ahb_master_i.write(ADDR_SEQ_B_CONTROL, 32'h6);
      sbgr_ahb_master_i.write(ADDR_LOW_THRESHOLD, 32'h4000);
      sbgr_ahb_master_i.write(ADDR_HIGH_THRESHOLD, 32'hc000);
      for (int i = 0; i < 9; i++)
      begin
         pulse(1'b1, TBL[i][19:16], TBL[i][11:0]);
         reqs(3'h4);
         rchk("result", ADDR_GLOBAL_RESULT, word(1'b1, 1'b0, TBL[i]));
      end
      last = word(1'b0, 1'b0, TBL[8]);
      rchk("result", ADDR_GLOBAL_RESULT, last);
      pulse(1'b0, 4'h5, 12'habc);
      rchk("result", ADDR_GLOBAL_RESULT, last);
      $display("field test done");
      pulse(1'b1, 4'h4, 12'h500);
      pulse(1'b1, 4'h4, 12'h600);
      reqs(3'h6);
      rchk("result", ADDR_GLOBAL_RESULT, word(1'b1, 1'b1, 20'h40600));
      reqs(3'h0);
      rchk("result", ADDR_GLOBAL_RESULT, word(1'b0, 1'b0, 20'h40600));
      $display("overrun test done");
      rchk("status", ADDR_INT_STATUS, 32'h3);
      sbgr_ahb_master_i.write(ADDR_INT_MASK, 32'h1);
      reqs(3'h1);
      sbgr_ahb_master_i.write(ADDR_INT_STATUS, 32'h1);
      reqs(3'h0);
      rchk("status", ADDR_INT_STATUS, 32'h2);
      sbgr_ahb_master_i.write(ADDR_INT_MASK, 32'h3);
      reqs(3'h1);
      sbgr_ahb_master_i.write(ADDR_INT_STATUS, 32'h2);
      reqs(3'h0);
      $display("interrupt test done");
      sbgr_ahb_master_i.write(ADDR_SEQ_B_CONTROL, 32'h7);
      pulse(1'b1, 4'h4, 12'h700);
      pulse(1'b1, 4'h4, 12'h710);
      reqs(3'h0);
      rchk("status", ADDR_INT_STATUS, 32'h0);
      last = word(1'b0, 1'b0, 20'h40710);
      rchk("result", ADDR_GLOBAL_RESULT, {2'h3, last[29:0]});
      sbgr_ahb_master_i.write(ADDR_GLOBAL_RESULT, 32'hfc0ffff0);
      rchk("result", ADDR_GLOBAL_RESULT, last);
      $display("mode and write test done");
      // two back-to-back conversions on one channel, the second one below low
      @(posedge clock);
      conv <= {1'b1, 1'b1, 4'h5, 12'h800};
      @(posedge clock);
      conv <= {1'b1, 1'b1, 4'h5, 12'h100};
      @(posedge clock);
      conv <= '0;
      rchk("result", ADDR_GLOBAL_RESULT, word(1'b1, 1'b1, 20'h56100));
      // reset in mid-run over a fresh result; flags, history and enables clear
      pulse(1'b1, 4'h5, 12'h200);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      reqs(3'h0);
      rchk("result", ADDR_GLOBAL_RESULT, 32'h0);
      pulse(1'b1, 4'h5, 12'h100);
      pulse(1'b1, 4'h5, 12'h100);
      reqs(3'h0);
      rchk("status", ADDR_INT_STATUS, 32'h0);
      rchk("result", ADDR_GLOBAL_RESULT, word(1'b1, 1'b1, 20'h50100));
      $display("crossing and reset test done");
      complete_run();
   end
endmodule
